// [rtl/adcsq_pkg.sv]
// constants and types shared by the conversion sequencer files
package adcsq_pkg;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned CH_W      = 4;
  localparam int unsigned SLOT_W    = 3;
  localparam int unsigned NUM_SLOTS = 8;
  localparam int unsigned TRIG_N    = 3;

  // register byte addresses
  localparam logic [ADDR_W-1:0] OFF_NMODE     = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_NCHAN     = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PRIO      = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_MON       = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_TRIG      = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_PRES      = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_SLOT_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_SLOT_END  = 8'h60;
  localparam int unsigned       SLOT_IDX_LO   = 3;
  localparam int unsigned       SLOT_LO_BIT   = 2;

  // normal_mode_reg fields
  localparam int unsigned NM_START  = 0;
  localparam int unsigned NM_SCAN   = 1;
  localparam int unsigned NM_REPEAT = 2;
  localparam int unsigned NM_ITM_LO = 3;
  localparam int unsigned NM_BUSY   = 6;
  localparam int unsigned NM_DONE   = 7;

  // priority_ctrl_reg fields
  localparam int unsigned PR_CH_LO = 0;
  localparam int unsigned PR_START = 4;
  localparam int unsigned PR_BUSY  = 5;
  localparam int unsigned PR_DONE  = 6;

  // monitor register fields
  localparam int unsigned MON_EN      = 0;
  localparam int unsigned MON_DIR     = 1;
  localparam int unsigned MON_SLOT_LO = 2;
  localparam int unsigned MON_CMP_LO  = 16;

  // trigger_config_reg and result slot layout
  localparam int unsigned TRIG_SRC_LO = 6;
  localparam int unsigned LO_OVR      = 0;
  localparam int unsigned LO_RF       = 1;
  localparam int unsigned LO_DATA_LO  = 6;
  localparam int unsigned UP_SHIFT    = 2;

  localparam logic [1:0]        ITM_FOUR        = 2'h1;
  localparam logic [1:0]        ITM_EIGHT       = 2'h2;
  localparam logic [SLOT_W-1:0] SLOT_LAST_FOUR  = 3'h3;
  localparam logic [SLOT_W-1:0] SLOT_LAST_EIGHT = 3'h7;

  typedef enum logic [1:0] {SQ_IDLE, SQ_NORM, SQ_PRIO} adcsq_state_t;
endpackage : adcsq_pkg

// [rtl/adcsq_result_slot.sv]
// one conversion result slot with stored and overrun flags
`timescale 1ns/1ns
module adcsq_result_slot #(
  parameter int unsigned RES_W = 10
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             clkEn,
  input  wire logic             wrEn,
  input  wire logic             rdClr,
  input  wire logic [RES_W-1:0] wrData,
  output logic      [RES_W-1:0] slotData_q,
  output logic                  stored_q,
  output logic                  overrun_q
);
  logic storedD;
  logic overrunD;

  // new result wins over a read clear in the same cycle
  assign storedD  = wrEn | (stored_q & ~rdClr);
  assign overrunD = (wrEn & stored_q & ~rdClr) | (overrun_q & ~rdClr);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      slotData_q <= '0;
      stored_q   <= 1'b0;
      overrun_q  <= 1'b0;
    end else if (clkEn) begin
      if (wrEn) begin
        slotData_q <= wrData;
      end
      stored_q  <= storedD;
      overrun_q <= overrunD;
    end
  end
endmodule : adcsq_result_slot

// [rtl/adcsq_sequencer.sv]
// conversion sequencer: modes, slots, priority preemption, monitor, ahb-lite registers
`timescale 1ns/1ns
module adcsq_sequencer #(
  parameter int unsigned RES_W = 10
) (
  input  wire logic                         core_clk,
  input  wire logic                         reset,
  input  wire logic                         clkEn,
  input  wire logic                         hsel,
  input  wire logic [adcsq_pkg::ADDR_W-1:0] haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  input  wire logic                         hready,
  output logic      [31:0]                  hrdata,
  output logic                              hreadyout,
  output logic                              hresp,
  input  wire logic [adcsq_pkg::TRIG_N-1:0] prioHwTrig,
  output logic                              convStart,
  output logic                              convAbort,
  output logic      [adcsq_pkg::CH_W-1:0]   convChannel,
  input  wire logic                         convDone,
  input  wire logic [RES_W-1:0]             convData,
  output logic                              normalDoneIrq,
  output logic                              priorityDoneIrq,
  output logic                              monitorIrq
);
  import adcsq_pkg::*;

  if (RES_W < 3 || RES_W > 16) begin : g_chk
    $error("RES_W must lie between 3 and 16");
  end

  // bus address phase
  logic              addrPhase;
  logic              rdAcc;
  logic              wrPend_q;
  logic [ADDR_W-1:0] wrAddr_q;
  logic              wrNmode;
  logic              wrNchan;
  logic              wrPrio;
  logic              wrMon;
  logic              wrTrig;
  logic              rdNmode;
  logic              rdPrio;
  logic [ADDR_W-1:0] slotOff;
  logic              slotHit;
  logic [SLOT_W-1:0] slotIdx;
  logic              slotLo;

  assign addrPhase = hsel & htrans[1] & hready;
  assign rdAcc     = addrPhase & ~hwrite;
  assign wrNmode   = wrPend_q & (wrAddr_q == OFF_NMODE);
  assign wrNchan   = wrPend_q & (wrAddr_q == OFF_NCHAN);
  assign wrPrio    = wrPend_q & (wrAddr_q == OFF_PRIO);
  assign wrMon     = wrPend_q & (wrAddr_q == OFF_MON);
  assign wrTrig    = wrPend_q & (wrAddr_q == OFF_TRIG);
  assign rdNmode   = rdAcc & (haddr == OFF_NMODE);
  assign rdPrio    = rdAcc & (haddr == OFF_PRIO);
  assign slotOff   = haddr - OFF_SLOT_BASE;
  assign slotHit   = (haddr >= OFF_SLOT_BASE) && (haddr < OFF_SLOT_END);
  assign slotIdx   = slotOff[SLOT_IDX_LO +: SLOT_W];
  assign slotLo    = slotOff[SLOT_LO_BIT];

  // software settings
  logic              scan_q;
  logic              repeat_q;
  logic [1:0]        itm_q;
  logic [CH_W-1:0]   chSel_q;
  logic [CH_W-1:0]   prioCh_q;
  logic              monEn_q;
  logic              monDir_q;
  logic [SLOT_W-1:0] monSlot_q;
  logic [RES_W-1:0]  monCmp_q;
  logic [1:0]        trigSrc_q;

  // sequencer state
  adcsq_state_t      state_q;
  adcsq_state_t      state_d;
  logic [CH_W-1:0]   chan_q;
  logic [CH_W-1:0]   chan_d;
  logic [SLOT_W-1:0] slotPtr_q;
  logic [SLOT_W-1:0] slotPtr_d;
  logic              repLat_q;
  logic              repLat_d;
  logic              resume_q;
  logic              resume_d;
  logic              nBusy_q;
  logic              nBusy_d;
  logic              nDone_q;
  logic              pBusy_q;
  logic              pBusy_d;
  logic              pDone_q;
  logic [RES_W-1:0]  prioRes_q;
  logic              startP_d;
  logic              abortP_d;
  logic [CH_W-1:0]   chOut_d;

  // completion, trigger and start request decode
  logic              normDone;
  logic              prioDone;
  logic              fixedRep;
  logic [SLOT_W-1:0] wrSlot;
  logic              scanLast;
  logic              groupEnd;
  logic              cycleEnd;
  logic              stopNow;
  logic              doneEvt;
  logic              monHit;
  logic [1:0]        trigIdx;
  logic              hwHit;
  logic              prioReq;
  logic              prioAccept;
  logic              nStartReq;
  logic [CH_W-1:0]   firstCh;

  assign normDone   = convDone & (state_q == SQ_NORM);
  assign prioDone   = convDone & (state_q == SQ_PRIO);
  assign fixedRep   = repeat_q & ~scan_q;
  assign wrSlot     = fixedRep ? slotPtr_q : chan_q[SLOT_W-1:0];
  assign scanLast   = ~scan_q | (chan_q == chSel_q);
  assign groupEnd   = (itm_q == ITM_FOUR)  ? (slotPtr_q == SLOT_LAST_FOUR) :
                      (itm_q == ITM_EIGHT) ? (slotPtr_q == SLOT_LAST_EIGHT) : 1'b1;
  assign cycleEnd   = fixedRep ? groupEnd : scanLast;
  assign stopNow    = ~repeat_q & (repLat_q | scanLast);
  assign doneEvt    = normDone & (repeat_q ? cycleEnd : scanLast);
  assign monHit     = monEn_q & normDone & (wrSlot == monSlot_q) &
                      (monDir_q ? (convData > monCmp_q) : (convData < monCmp_q));
  assign trigIdx    = trigSrc_q - 2'h1;
  assign hwHit      = (trigSrc_q != 2'h0) & prioHwTrig[trigIdx];
  assign prioReq    = (wrPrio & hwdata[PR_START]) | hwHit;
  assign prioAccept = prioReq & ~pBusy_q;
  assign nStartReq  = wrNmode & hwdata[NM_START] & ~nBusy_q;
  assign firstCh    = hwdata[NM_SCAN] ? '0 : chSel_q;

  always_comb begin
    state_d   = state_q;
    chan_d    = chan_q;
    slotPtr_d = slotPtr_q;
    repLat_d  = repLat_q;
    resume_d  = resume_q;
    nBusy_d   = nBusy_q;
    pBusy_d   = pBusy_q;
    startP_d  = 1'b0;
    abortP_d  = 1'b0;
    chOut_d   = convChannel;
    case (state_q)
      SQ_IDLE: begin
        if (pBusy_q) begin
          startP_d = 1'b1;
          chOut_d  = prioCh_q;
          state_d  = SQ_PRIO;
        end else if (resume_q) begin
          startP_d = 1'b1;
          chOut_d  = chan_q;
          resume_d = 1'b0;
          state_d  = SQ_NORM;
        end
      end
      SQ_NORM: begin
        if (convDone) begin
          if (fixedRep) begin
            slotPtr_d = groupEnd ? '0 : slotPtr_q + 3'h1;
          end
          if (stopNow) begin
            nBusy_d = 1'b0;
            state_d = SQ_IDLE;
          end else begin
            chan_d   = scan_q ? (scanLast ? '0 : chan_q + 4'h1) : chSel_q;
            startP_d = 1'b1;
            chOut_d  = chan_d;
          end
        end else if (pBusy_q) begin
          abortP_d = 1'b1;
          resume_d = 1'b1;
          startP_d = 1'b1;
          chOut_d  = prioCh_q;
          state_d  = SQ_PRIO;
        end
      end
      SQ_PRIO: begin
        if (convDone) begin
          pBusy_d = 1'b0;
          state_d = SQ_IDLE;
        end
      end
      default: begin
        state_d = SQ_IDLE;
      end
    endcase
    if (prioAccept) begin
      pBusy_d = 1'b1;
    end
    if (nStartReq) begin
      nBusy_d   = 1'b1;
      resume_d  = 1'b1;
      chan_d    = firstCh;
      slotPtr_d = '0;
      repLat_d  = hwdata[NM_REPEAT];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q   <= SQ_IDLE;
      chan_q    <= '0;
      slotPtr_q <= '0;
      repLat_q  <= 1'b0;
      resume_q  <= 1'b0;
      nBusy_q   <= 1'b0;
      pBusy_q   <= 1'b0;
    end else if (clkEn) begin
      state_q   <= state_d;
      chan_q    <= chan_d;
      slotPtr_q <= slotPtr_d;
      repLat_q  <= repLat_d;
      resume_q  <= resume_d;
      nBusy_q   <= nBusy_d;
      pBusy_q   <= pBusy_d;
    end
  end

  // sticky done flags, a new event wins over the read clear
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      nDone_q   <= 1'b0;
      pDone_q   <= 1'b0;
      prioRes_q <= '0;
    end else if (clkEn) begin
      nDone_q <= doneEvt | (nDone_q & ~rdNmode);
      pDone_q <= prioDone | (pDone_q & ~rdPrio);
      if (prioDone) begin
        prioRes_q <= convData;
      end
    end
  end

  // converter handshake and interrupt pulses
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      convStart       <= 1'b0;
      convAbort       <= 1'b0;
      convChannel     <= '0;
      normalDoneIrq   <= 1'b0;
      priorityDoneIrq <= 1'b0;
      monitorIrq      <= 1'b0;
    end else if (clkEn) begin
      convStart       <= startP_d;
      convAbort       <= abortP_d;
      convChannel     <= chOut_d;
      normalDoneIrq   <= doneEvt;
      priorityDoneIrq <= prioDone;
      monitorIrq      <= monHit;
    end
  end

  // software settings, written in the data phase
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      scan_q    <= 1'b0;
      repeat_q  <= 1'b0;
      itm_q     <= '0;
      chSel_q   <= '0;
      prioCh_q  <= '0;
      monEn_q   <= 1'b0;
      monDir_q  <= 1'b0;
      monSlot_q <= '0;
      monCmp_q  <= '0;
      trigSrc_q <= '0;
    end else if (clkEn) begin
      if (wrNmode) begin
        scan_q   <= hwdata[NM_SCAN];
        repeat_q <= hwdata[NM_REPEAT];
        itm_q    <= hwdata[NM_ITM_LO +: 2];
      end
      if (wrNchan) begin
        chSel_q <= hwdata[CH_W-1:0];
      end
      if (wrPrio) begin
        prioCh_q <= hwdata[PR_CH_LO +: CH_W];
      end
      if (wrMon) begin
        monEn_q   <= hwdata[MON_EN];
        monDir_q  <= hwdata[MON_DIR];
        monSlot_q <= hwdata[MON_SLOT_LO +: SLOT_W];
        monCmp_q  <= hwdata[MON_CMP_LO +: RES_W];
      end
      if (wrTrig) begin
        trigSrc_q <= hwdata[TRIG_SRC_LO +: 2];
      end
    end
  end

  // result slots
  logic [RES_W-1:0] slotData [NUM_SLOTS];
  logic             slotRf   [NUM_SLOTS];
  logic             slotOvr  [NUM_SLOTS];

  for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_slot
    logic slotWr;
    logic slotClr;
    assign slotWr  = normDone & (wrSlot == SLOT_W'(i));
    assign slotClr = rdAcc & slotHit & slotLo & (slotIdx == SLOT_W'(i));
    adcsq_result_slot #(
      .RES_W(RES_W)
    ) u_slot (
      .core_clk  (core_clk),
      .reset     (reset),
      .clkEn     (clkEn),
      .wrEn      (slotWr),
      .rdClr     (slotClr),
      .wrData    (convData),
      .slotData_q(slotData[i]),
      .stored_q  (slotRf[i]),
      .overrun_q (slotOvr[i])
    );
  end

  // read data selection
  logic [31:0] nmodeRd;
  logic [31:0] prioRd;
  logic [31:0] monRd;
  logic [31:0] slotUpRd;
  logic [31:0] slotLoRd;
  logic [31:0] rdMux;

  assign nmodeRd  = (32'(scan_q) << NM_SCAN) | (32'(repeat_q) << NM_REPEAT) |
                    (32'(itm_q) << NM_ITM_LO) | (32'(nBusy_q) << NM_BUSY) | (32'(nDone_q) << NM_DONE);
  assign prioRd   = (32'(prioCh_q) << PR_CH_LO) | (32'(pBusy_q) << PR_BUSY) | (32'(pDone_q) << PR_DONE);
  assign monRd    = (32'(monEn_q) << MON_EN) | (32'(monDir_q) << MON_DIR) |
                    (32'(monSlot_q) << MON_SLOT_LO) | (32'(monCmp_q) << MON_CMP_LO);
  assign slotUpRd = 32'(slotData[slotIdx] >> UP_SHIFT);
  assign slotLoRd = (32'(slotData[slotIdx][UP_SHIFT-1:0]) << LO_DATA_LO) |
                    (32'(slotRf[slotIdx]) << LO_RF) | (32'(slotOvr[slotIdx]) << LO_OVR);
  assign rdMux    = (haddr == OFF_NMODE) ? nmodeRd :
                    (haddr == OFF_NCHAN) ? 32'(chSel_q) :
                    (haddr == OFF_PRIO)  ? prioRd :
                    (haddr == OFF_MON)   ? monRd :
                    (haddr == OFF_TRIG)  ? (32'(trigSrc_q) << TRIG_SRC_LO) :
                    (haddr == OFF_PRES)  ? 32'(prioRes_q) :
                    slotHit              ? (slotLo ? slotLoRd : slotUpRd) : 32'h0000_0000;

  // read data is fetched at the address phase, so the slave never waits
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wrPend_q  <= 1'b0;
      wrAddr_q  <= '0;
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (clkEn) begin
      wrPend_q  <= addrPhase & hwrite;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addrPhase) begin
        wrAddr_q <= haddr;
      end
      if (rdAcc) begin
        hrdata <= rdMux;
      end
    end
  end
endmodule : adcsq_sequencer

// [tb/adcsq_sequencer_assertions.sv]
// port-level checker for the conversion sequencer
`timescale 1ns/1ns
module adcsq_sequencer_assertions (
  input wire logic                       core_clk,
  input wire logic                       reset,
  input wire logic                       convStart,
  input wire logic                       convAbort,
  input wire logic [adcsq_pkg::CH_W-1:0] convChannel,
  input wire logic                       convDone,
  input wire logic                       normalDoneIrq,
  input wire logic                       priorityDoneIrq
);
  import adcsq_pkg::*;
  logic            open_q;
  logic            prio_q;
  logic [CH_W-1:0] last_q;
  logic [CH_W-1:0] susp_q;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      open_q <= 1'b0;
      prio_q <= 1'b0;
      last_q <= '0;
      susp_q <= '0;
    end else begin
      open_q <= convStart | (open_q & ~convDone);
      prio_q <= convAbort | (prio_q & ~priorityDoneIrq);
      last_q <= convChannel;
      if (convAbort) begin
        susp_q <= last_q;
      end
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_abort_with_start:
    assert property (convAbort |-> convStart && open_q) else $error("abort not paired with restart");
  a_start_exclusive:
    assert property (convStart && open_q |-> convAbort) else $error("start while converting");
  a_normal_irq_cause:
    assert property (normalDoneIrq |-> $past(convDone) && !prio_q) else $error("normal irq without result");
  a_prio_irq_cause:
    assert property (priorityDoneIrq |-> $past(convDone) && !normalDoneIrq) else $error("priority irq bad");
  a_resume_channel:
    assert property (priorityDoneIrq && prio_q |=> convStart && convChannel == susp_q) else $error("bad resume");
  a_prio_quiet:
    assert property (prio_q |-> !normalDoneIrq) else $error("normal irq during priority");
  a_irq_pulse:
    assert property (normalDoneIrq |=> !normalDoneIrq) else $error("normal irq too long");
  a_prio_once:
    assert property (priorityDoneIrq |=> !priorityDoneIrq) else $error("priority irq too long");
  c_preempt: cover property (convAbort);
  c_resume: cover property (priorityDoneIrq && prio_q);
  c_repeat: cover property (normalDoneIrq ##1 convStart);
endmodule : adcsq_sequencer_assertions

bind adcsq_sequencer adcsq_sequencer_assertions i_adcsq_sequencer_assertions (.core_clk(core_clk), .reset(reset),
  .convStart(convStart), .convAbort(convAbort), .convChannel(convChannel), .convDone(convDone),
  .normalDoneIrq(normalDoneIrq), .priorityDoneIrq(priorityDoneIrq));

// [tb/adcsq_conv_model.sv]
// converter core model: answers a start after a set latency
`timescale 1ns/1ns
module adcsq_conv_model #(
  parameter int unsigned RES_W = 10
) (
  input  wire logic                       core_clk,
  input  wire logic                       reset,
  input  wire logic                       convStart,
  input  wire logic [adcsq_pkg::CH_W-1:0] convChannel,
  input  wire logic [7:0]                 latency,
  input  wire logic [RES_W-1:0]           dataBase,
  output logic                            convDone,
  output logic      [RES_W-1:0]           convData
);
  import adcsq_pkg::*;
  logic [7:0]      left;
  logic [CH_W-1:0] ch;
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      left     <= '0;
      ch       <= '0;
      convDone <= 1'b0;
      convData <= '0;
    end else begin
      convDone <= 1'b0;
      convData <= ~convData;
      // a restart drops any aborted conversion
      if (convStart) begin
        left <= latency;
        ch   <= convChannel;
      end else if (left == 8'h1) begin
        left     <= '0;
        convDone <= 1'b1;
        convData <= dataBase + RES_W'(ch);
      end else if (left != 8'h0) begin
        left <= left - 8'h1;
      end
    end
  end
endmodule : adcsq_conv_model

// [tb/test_adcsq_sequencer.sv]
// self-checking bench for the conversion sequencer
`timescale 1ns/1ns
module test_adcsq_sequencer;
  import adcsq_pkg::*;
  typedef struct {logic [7:0] cfg; logic [3:0] ch; int n; logic [2:0] slot; logic ovr;} adcsq_row_t;
  logic        core_clk = 0, reset = 1, clkEn = 1, hsel = 0, hwrite = 0, hreadyout, hresp;
  logic [7:0]  haddr = 0, lat = 8'd4;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2, trig = 0;
  logic [31:0] hwdata = 0, hrdata, r;
  logic        convStart, convAbort, convDone, nIrq, pIrq, mIrq;
  logic [3:0]  convChannel;
  logic [9:0]  convData, base = 10'h2c0;
  int          bad_count = 0, n_compared = 0, starts = 0, nCnt = 0, pCnt = 0, mCnt = 0, c0, p0;
  adcsq_row_t  rows[8] = '{'{8'h01, 3, 1, 3, 0}, '{8'h01, 11, 1, 3, 0}, '{8'h03, 2, 3, 2, 0},
    '{8'h03, 9, 10, 1, 1}, '{8'h05, 5, 2, 0, 0}, '{8'h0d, 5, 5, 3, 0}, '{8'h15, 5, 9, 7, 0}, '{8'h07, 3, 5, 3, 0}};
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    starts <= starts + int'(convStart);
    nCnt   <= nCnt + int'(nIrq);
    pCnt   <= pCnt + int'(pIrq);
    mCnt   <= mCnt + int'(mIrq);
  end
  adcsq_sequencer #(.RES_W(10)) i_adcsq_sequencer (.core_clk(core_clk), .reset(reset), .clkEn(clkEn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .prioHwTrig(trig), .convStart(convStart),
    .convAbort(convAbort), .convChannel(convChannel), .convDone(convDone), .convData(convData),
    .normalDoneIrq(nIrq), .priorityDoneIrq(pIrq), .monitorIrq(mIrq));
  adcsq_conv_model #(.RES_W(10)) i_adcsq_conv_model (.core_clk(core_clk), .reset(reset), .convStart(convStart),
    .convChannel(convChannel), .latency(lat), .dataBase(base), .convDone(convDone), .convData(convData));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr  <= a;
    hwrite <= w;
    hsel   <= 1'b1;
    htrans <= 2'h2;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  task automatic waitCnt(ref int c, input int target);
    for (int i = 0; i < 3000 && c < target; i++) @(posedge core_clk);
    check(32'(c >= target), 32'h1);
  endtask : waitCnt
  task automatic print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  initial begin
    #1000000;
    bad_count++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    foreach (rows[i]) begin
      c0 = starts;
      p0 = nCnt;
      bus(OFF_NCHAN, 1, 32'(rows[i].ch));
      bus(OFF_NMODE, 1, 32'(rows[i].cfg));
      waitCnt(nCnt, p0 + 1);
      check(32'(starts - c0), 32'(rows[i].n));
      bus(OFF_NMODE, 0, 0);
      check(r & 32'hc0, rows[i].cfg[2] ? 32'hc0 : 32'h80);
      if (rows[i].cfg[2]) begin
        bus(OFF_NMODE, 1, 32'(rows[i].cfg & 8'hfa));
        for (int k = 0; k < 40 && r[6] !== 1'b0; k++) bus(OFF_NMODE, 0, 0);
        c0 = starts;
        repeat (20) @(posedge core_clk);
        check({r[6], 31'(starts - c0)}, 32'h0);
      end else begin
        bus(OFF_NMODE, 0, 0);
        check(r & 32'h80, 32'h0);
      end
      bus(OFF_SLOT_BASE + 8'(rows[i].slot * 8), 0, 0);
      check(r, 32'((base + 10'(rows[i].ch)) >> 2));
      bus(OFF_SLOT_BASE + 8'(rows[i].slot * 8 + 4), 0, 0);
      if (!rows[i].cfg[2]) check(r, {24'h0, base[1:0] + rows[i].ch[1:0], 4'h0, 1'b1, rows[i].ovr});
      $display("row %0d done", i);
    end
    lat <= 8'd12;
    c0 = starts;
    p0 = pCnt;
    bus(OFF_NMODE, 1, 32'h03);
    waitCnt(starts, c0 + 3);
    bus(OFF_PRIO, 1, 32'h1f);
    bus(OFF_PRIO, 1, 32'h1f);
    bus(OFF_NMODE, 0, 0);
    check(r & 32'hc0, 32'h40);
    waitCnt(pCnt, p0 + 1);
    bus(OFF_PRES, 0, 0);
    check(r, 32'(base + 10'hf));
    bus(OFF_PRIO, 0, 0);
    check(r & 32'h60, 32'h40);
    bus(OFF_PRIO, 0, 0);
    check(r & 32'h40, 32'h0);
    waitCnt(nCnt, nCnt + 1);
    check(32'(starts - c0), 32'h6);
    check(32'(pCnt - p0), 32'h1);
    $display("preempt done");
    for (int s = 1; s < 4; s++) begin
      p0 = pCnt;
      bus(OFF_PRIO, 1, 32'h6);
      bus(OFF_TRIG, 1, 32'(s << 6));
      trig <= 3'h7 ^ 3'(1 << (s - 1));
      @(posedge core_clk);
      trig <= 3'h0;
      repeat (40) @(posedge core_clk);
      check(32'(pCnt - p0), 32'h0);
      trig <= 3'(1 << (s - 1));
      @(posedge core_clk);
      trig <= 3'h0;
      waitCnt(pCnt, p0 + 1);
      bus(OFF_PRES, 0, 0);
      check(r, 32'(base + 10'h6));
    end
    $display("hardware trigger done");
    bus(OFF_NCHAN, 1, 32'h4);
    for (int d = 1; d >= 0; d--) begin
      p0 = mCnt;
      c0 = nCnt;
      bus(OFF_MON, 1, {6'h0, base + 10'h3, 11'h0, 3'h4, d[0], 1'b1});
      bus(OFF_NMODE, 1, 32'h01);
      waitCnt(nCnt, c0 + 1);
      repeat (4) @(posedge core_clk);
      check(32'(mCnt - p0), 32'(d));
    end
    $display("monitor done");
    // a trigger seen while the clock enable is low must be lost
    p0 = pCnt;
    clkEn <= 1'b0;
    trig  <= 3'h4;
    @(posedge core_clk);
    clkEn <= 1'b1;
    trig  <= 3'h0;
    repeat (40) @(posedge core_clk);
    check(32'(pCnt - p0), 32'h0);
    trig <= 3'h4;
    @(posedge core_clk);
    trig <= 3'h0;
    waitCnt(pCnt, p0 + 1);
    $display("freeze done");
    // reset in mid-run: outputs idle, settings and flags cleared
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    check(hrdata, 32'h0);
    check({25'(convChannel), hreadyout, hresp, convStart, convAbort, nIrq, pIrq, mIrq}, 32'h40);
    reset <= 1'b0;
    bus(OFF_PRIO, 0, 0);
    check(r, 32'h0);
    bus(OFF_SLOT_BASE + 8'h24, 0, 0);
    check(r, 32'h0);
    $display("reset done");
    print_verdict();
  end
endmodule : test_adcsq_sequencer
